// File: mfr_regs.svh
// Purpose: offsets, field positions, reset values and counts of the read engine
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   definitions only
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define MFR_OFS_CTRL       8'h00
`define MFR_OFS_STATUS     8'h04
`define MFR_OFS_MEM_ADDR   8'h08
`define MFR_OFS_MEM_DATA   8'h0C
`define MFR_OFS_CUR_ADDR   8'h10

// ****************************************
// control fields
// ****************************************
`define MFR_CTRL_QA        0
`define MFR_CTRL_FLN       1
`define MFR_CTRL_BUSY      2

// ****************************************
// status fields
// ****************************************
`define MFR_ST_CRM_DUAL    0
`define MFR_ST_CRM_QUAD    1
`define MFR_ST_WRAP_DIS    2
`define MFR_ST_WRAP_LEN    3
`define MFR_ST_DUMMY_SEL   5
`define MFR_ST_LINK_ACT    7
`define MFR_ST_MODE_BYTE   8

// ****************************************
// reset values
// ****************************************
`define MFR_RST_WRAP_DIS   1'b1
`define MFR_RST_WRAP_LEN   2'h0
`define MFR_RST_DUMMY_SEL  2'h0
`define MFR_RST_MODE_BYTE  8'h00

// ****************************************
// opcodes
// ****************************************
`define MFR_OP_QUAD_OUT    8'h6B
`define MFR_OP_DUAL_IO     8'hBB
`define MFR_OP_QUAD_IO     8'hEB
`define MFR_OP_FAST        8'h0B
`define MFR_OP_BURST_WRAP  8'h0C
`define MFR_OP_SET_WRAP    8'h77
`define MFR_OP_SET_PARAM   8'hC0
`define MFR_OP_CRM_RESET   8'hFF

// ****************************************
// link bit and clock counts, continuation mode match
// ****************************************
`define MFR_OPCODE_BITS    6'd8
`define MFR_ADDR_BITS      6'd24
`define MFR_MODE_BITS      6'd8
`define MFR_WRAPCFG_BITS   6'd32
`define MFR_PARAM_BITS     6'd8
`define MFR_DUMMY_QUAD_OUT 4'd8
`define MFR_DUMMY_QIO_SPI  4'd4
`define MFR_DUMMY_BASE     4'd4
`define MFR_FLN_MODE_CLKS  4'd2
`define MFR_CRM_MATCH      2'b10

`endif

// File: mfr_pkg.sv
// Purpose: types shared by the read engine files
// Assumes: constants come from mfr_regs.svh
// Notes:   none
`default_nettype none

package mfr_pkg;

   typedef enum logic [2:0] {
      MFR_IDLE   = 3'b000,
      MFR_CMD    = 3'b001,
      MFR_ADDR   = 3'b011,
      MFR_MODE   = 3'b010,
      MFR_DUMMY  = 3'b110,
      MFR_DATA   = 3'b111,
      MFR_CFG    = 3'b101,
      MFR_IGNORE = 3'b100
   } mfr_state_e;

   typedef enum logic [2:0] {
      MFR_K_NONE    = 3'h0,
      MFR_K_READ    = 3'h1,
      MFR_K_WRAPCFG = 3'h2,
      MFR_K_PARAM   = 3'h3,
      MFR_K_CRMRST  = 3'h4
   } mfr_kind_e;

   // lane code: 0 = one line, 1 = two lines, 2 = four lines
   typedef struct packed {
      mfr_kind_e  kind;
      logic [1:0] addr_lane;
      logic       has_mode;
      logic [3:0] mode_clks;
      logic [3:0] dummy_clks;
      logic [1:0] data_lane;
      logic       wrap;
      logic [1:0] cont;
   } mfr_plan_s;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } mfr_wb_req_s;

   typedef struct packed {
      logic       sclk;
      logic       cs_n;
      logic [3:0] io;
   } mfr_link_in_s;

endpackage : mfr_pkg

`default_nettype wire

// File: mfr_sync.sv
// Purpose: two-stage synchroniser for link pins
// Assumes: inputs are asynchronous to clk_i
// Notes:   first stage feeds only the second
`default_nettype none

module mfr_sync #(
   parameter int W = 6
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   // ****************************************
   // per-bit flip-flop pair
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic [1:0] stage_reg;
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               stage_reg <= 2'h0;
            end else if (ce_i) begin
               stage_reg <= {stage_reg[0], d_i[g]};
            end
         end
         assign q_o[g] = stage_reg[1];
      end
   endgenerate

endmodule // mfr_sync

`default_nettype wire

// File: mfr_engine.sv
// Purpose: multi-line read engine of a serial NOR flash, seen from inside the device
// Assumes: link pins sampled by clk_i at 250 MHz, serial clock much slower
// Notes:   flash contents held in a local array loaded over Wishbone
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`include "mfr_regs.svh"
`default_nettype none

// Function
// - quad output read: addr, dummy byte, x4 data
// - start anywhere, address increments per byte
// - quad reads need quad enable set outside four-line mode
// - dual I/O: addr and mode x2, data x2
// - dual continuation skips opcode next access
// - quad continuation skips opcode next access
// - other mode bits leave continuous read
// - reset command clears stored mode byte
// - quad I/O: addr, mode, four dummies x4
// - four-line quad I/O dummy from parameters
// - four-line quad I/O never wraps
// - wrap disable bit and length select
// - wrap inside aligned section until deselect
// - wrap bits persist for later quad reads
// - burst wrap read: fast read that wraps
// - parameter bits 5:4 choose dummy clocks
// - parameter bits 1:0 choose burst length
// - wrap length survives mode change
// - data out falling, inputs sampled rising
// - reads rejected during embedded cycle
module mfr_engine
   import mfr_pkg::*;
#(
   parameter int MEM_AW = 12
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  io_i,
   output logic      [3:0]  io_o,
   output logic      [3:0]  io_oe_o
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      mfr_state_e  st;
      mfr_plan_s   plan;
      logic        ack;
      logic [31:0] dat;
      logic        qa;
      logic        fln;
      logic        busy;
      logic        crm_dual;
      logic        crm_quad;
      logic [7:0]  mode_byte;
      logic        wrap_dis;
      logic [1:0]  wrap_len;
      logic [1:0]  dummy_sel;
      logic [23:0] mem_addr;
      logic [23:0] addr;
      logic [31:0] sh;
      logic [5:0]  cnt;
      logic [7:0]  out_sh;
      logic [2:0]  nib;
      logic [3:0]  io;
      logic [3:0]  oe;
      logic        sclk_prev;
      logic        cs_prev;
   } mfr_core_s;

   mfr_core_s   s_reg;
   mfr_core_s   s_next;
   logic [7:0]  mem [2**MEM_AW];
   logic [5:0]  pins_s;
   mfr_link_in_s lk;
   mfr_wb_req_s  wb;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        mem_we;
   logic [7:0]  rd_byte;

   // ****************************************
   // pin synchronisers
   // ****************************************
   mfr_sync #(
      .W (6)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   ({sclk_i, cs_n_i, io_i}),
      .q_o   (pins_s)
   );

   assign lk        = mfr_link_in_s'(pins_s);
   assign wb        = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
   assign sclk_rise = lk.sclk & ~s_reg.sclk_prev & ~lk.cs_n;
   assign sclk_fall = ~lk.sclk & s_reg.sclk_prev & ~lk.cs_n;
   assign cs_fall   = ~lk.cs_n & s_reg.cs_prev;
   assign rd_byte   = mem[s_reg.addr[MEM_AW-1:0]];

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [5:0] lane_clks(input logic [1:0] lane, input logic [5:0] nbits);
      lane_clks = nbits >> lane;
   endfunction

   function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [1:0] lane,
                                             input logic [3:0] io);
      unique case (lane)
         2'd0:    shift_in = {sh[30:0], io[0]};
         2'd1:    shift_in = {sh[29:0], io[1:0]};
         default: shift_in = {sh[27:0], io};
      endcase
   endfunction

   // next byte address, wrapping inside an aligned 8/16/32/64 byte section
   function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
                                              input logic [1:0] len);
      logic [23:0] mask;
      logic [23:0] inc;
      mask = 24'((24'h8 << len) - 24'h1);
      inc  = a + 24'h1;
      if (wrap) begin
         next_addr = (a & ~mask) | (inc & mask);
      end else begin
         next_addr = inc;
      end
   endfunction

   // opcode decode, shared by opcode end and continuation start
   function automatic mfr_plan_s cmd_plan(input logic [7:0] op, input logic fln, input logic qa,
                                          input logic busy, input logic [1:0] dsel,
                                          input logic wdis);
      logic [3:0] pdum;
      mfr_plan_s  p;
      pdum = `MFR_DUMMY_BASE + {1'b0, dsel, 1'b0};
      p = '{MFR_K_NONE, 2'd2, 1'b0, 4'd0, 4'd0, 2'd2, 1'b0, 2'd0};
      unique case (op)
         `MFR_OP_QUAD_OUT: if (!fln && qa) begin
            p.kind       = MFR_K_READ;
            p.addr_lane  = 2'd0;
            p.dummy_clks = `MFR_DUMMY_QUAD_OUT;
         end
         `MFR_OP_DUAL_IO: if (!fln) begin
            p.kind      = MFR_K_READ;
            p.addr_lane = 2'd1;
            p.data_lane = 2'd1;
            p.has_mode  = 1'b1;
            p.mode_clks = 4'd4;
            p.cont      = 2'd1;
         end
         `MFR_OP_QUAD_IO: if (fln || qa) begin
            p.kind      = MFR_K_READ;
            p.has_mode  = 1'b1;
            p.mode_clks = `MFR_FLN_MODE_CLKS;
            p.cont      = 2'd2;
            if (fln) begin
               p.dummy_clks = pdum - `MFR_FLN_MODE_CLKS;
            end else begin
               p.dummy_clks = `MFR_DUMMY_QIO_SPI;
               p.wrap       = ~wdis;
            end
         end
         `MFR_OP_FAST: if (fln) begin
            p.kind       = MFR_K_READ;
            p.dummy_clks = pdum;
         end
         `MFR_OP_BURST_WRAP: if (fln) begin
            p.kind       = MFR_K_READ;
            p.dummy_clks = pdum;
            p.wrap       = 1'b1;
         end
         `MFR_OP_SET_WRAP: if (!fln) begin
            p.kind      = MFR_K_WRAPCFG;
            p.addr_lane = 2'd0;
         end
         `MFR_OP_SET_PARAM: if (fln) begin
            p.kind = MFR_K_PARAM;
         end
         `MFR_OP_CRM_RESET: p.kind = MFR_K_CRMRST;
         default: p.kind = MFR_K_NONE;
      endcase
      if (busy && p.kind == MFR_K_READ) begin
         p.kind = MFR_K_NONE;
      end
      if (fln && p.kind != MFR_K_NONE) begin
         p.addr_lane = 2'd2;
      end
      cmd_plan = p;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_next           = s_reg;
      mem_we           = 1'b0;
      s_next.sclk_prev = lk.sclk;
      s_next.cs_prev   = lk.cs_n;

      // bus slave, answers one cycle after the request
      s_next.ack = wb.cyc & wb.stb & ~s_reg.ack;
      if (wb.cyc && wb.stb && !s_reg.ack) begin
         s_next.dat = 32'h0;
         unique case (wb.adr)
            `MFR_OFS_CTRL: begin
               s_next.dat[`MFR_CTRL_QA]   = s_reg.qa;
               s_next.dat[`MFR_CTRL_FLN]  = s_reg.fln;
               s_next.dat[`MFR_CTRL_BUSY] = s_reg.busy;
               if (wb.we && wb.sel[0]) begin
                  s_next.qa   = wb.dat[`MFR_CTRL_QA];
                  s_next.fln  = wb.dat[`MFR_CTRL_FLN];
                  s_next.busy = wb.dat[`MFR_CTRL_BUSY];
               end
            end
            `MFR_OFS_STATUS: begin
               s_next.dat[`MFR_ST_CRM_DUAL]                       = s_reg.crm_dual;
               s_next.dat[`MFR_ST_CRM_QUAD]                       = s_reg.crm_quad;
               s_next.dat[`MFR_ST_WRAP_DIS]                       = s_reg.wrap_dis;
               s_next.dat[`MFR_ST_WRAP_LEN +: 2]                  = s_reg.wrap_len;
               s_next.dat[`MFR_ST_DUMMY_SEL +: 2]                 = s_reg.dummy_sel;
               s_next.dat[`MFR_ST_LINK_ACT]                       = (s_reg.st != MFR_IDLE);
               s_next.dat[`MFR_ST_MODE_BYTE +: 8]                 = s_reg.mode_byte;
            end
            `MFR_OFS_MEM_ADDR: begin
               s_next.dat[23:0] = s_reg.mem_addr;
               if (wb.we) begin
                  if (wb.sel[0]) s_next.mem_addr[7:0]   = wb.dat[7:0];
                  if (wb.sel[1]) s_next.mem_addr[15:8]  = wb.dat[15:8];
                  if (wb.sel[2]) s_next.mem_addr[23:16] = wb.dat[23:16];
               end
            end
            `MFR_OFS_MEM_DATA: begin
               s_next.dat[7:0] = mem[s_reg.mem_addr[MEM_AW-1:0]];
               if (wb.we && wb.sel[0]) begin
                  mem_we          = 1'b1;
                  s_next.mem_addr = s_reg.mem_addr + 24'h1;
               end
            end
            `MFR_OFS_CUR_ADDR: s_next.dat[23:0] = s_reg.addr;
            default:           s_next.dat = 32'h0;
         endcase
      end

      // link sequencer
      if (lk.cs_n) begin
         s_next.st = MFR_IDLE;
         s_next.oe = 4'h0;
      end else if (cs_fall) begin
         s_next.sh = 32'h0;
         if (s_reg.crm_dual || s_reg.crm_quad) begin
            s_next.plan = cmd_plan(s_reg.crm_dual ? `MFR_OP_DUAL_IO : `MFR_OP_QUAD_IO,
                                   s_reg.fln, s_reg.qa, s_reg.busy, s_reg.dummy_sel, s_reg.wrap_dis);
            s_next.st  = (s_next.plan.kind == MFR_K_READ) ? MFR_ADDR : MFR_IGNORE;
            s_next.cnt = lane_clks(s_next.plan.addr_lane, `MFR_ADDR_BITS);
         end else begin
            s_next.st  = MFR_CMD;
            s_next.cnt = lane_clks(s_reg.fln ? 2'd2 : 2'd0, `MFR_OPCODE_BITS);
         end
      end else if (sclk_rise) begin
         unique case (s_reg.st)
            MFR_CMD: begin
               s_next.sh  = shift_in(s_reg.sh, s_reg.fln ? 2'd2 : 2'd0, lk.io);
               s_next.cnt = s_reg.cnt - 6'd1;
               if (s_reg.cnt == 6'd1) begin
                  s_next.plan = cmd_plan(s_next.sh[7:0], s_reg.fln, s_reg.qa, s_reg.busy,
                                         s_reg.dummy_sel, s_reg.wrap_dis);
                  s_next.sh = 32'h0;
                  unique case (s_next.plan.kind)
                     MFR_K_READ: begin
                        s_next.st  = MFR_ADDR;
                        s_next.cnt = lane_clks(s_next.plan.addr_lane, `MFR_ADDR_BITS);
                     end
                     MFR_K_WRAPCFG: begin
                        s_next.st  = MFR_CFG;
                        s_next.cnt = lane_clks(s_next.plan.addr_lane, `MFR_WRAPCFG_BITS);
                     end
                     MFR_K_PARAM: begin
                        s_next.st  = MFR_CFG;
                        s_next.cnt = lane_clks(s_next.plan.addr_lane, `MFR_PARAM_BITS);
                     end
                     MFR_K_CRMRST: begin
                        s_next.crm_dual  = 1'b0;
                        s_next.crm_quad  = 1'b0;
                        s_next.mode_byte = `MFR_RST_MODE_BYTE;
                        s_next.st        = MFR_IGNORE;
                     end
                     default: s_next.st = MFR_IGNORE;
                  endcase
               end
            end
            MFR_ADDR: begin
               s_next.sh  = shift_in(s_reg.sh, s_reg.plan.addr_lane, lk.io);
               s_next.cnt = s_reg.cnt - 6'd1;
               if (s_reg.cnt == 6'd1) begin
                  s_next.addr = s_next.sh[23:0];
                  s_next.sh   = 32'h0;
                  s_next.nib  = 3'd0;
                  if (s_reg.plan.has_mode) begin
                     s_next.st  = MFR_MODE;
                     s_next.cnt = {2'b00, s_reg.plan.mode_clks};
                  end else if (s_reg.plan.dummy_clks != 4'd0) begin
                     s_next.st  = MFR_DUMMY;
                     s_next.cnt = {2'b00, s_reg.plan.dummy_clks};
                  end else begin
                     s_next.st = MFR_DATA;
                  end
               end
            end
            MFR_MODE: begin
               s_next.sh  = shift_in(s_reg.sh, s_reg.plan.addr_lane, lk.io);
               s_next.cnt = s_reg.cnt - 6'd1;
               if (s_reg.cnt == 6'd1) begin
                  s_next.mode_byte = s_next.sh[7:0];
                  // continuation only for the opcode that carried the mode byte
                  s_next.crm_dual = (s_reg.plan.cont == 2'd1) &&
                                    (s_next.sh[5:4] == `MFR_CRM_MATCH);
                  s_next.crm_quad = (s_reg.plan.cont == 2'd2) &&
                                    (s_next.sh[5:4] == `MFR_CRM_MATCH);
                  if (s_reg.plan.dummy_clks != 4'd0) begin
                     s_next.st  = MFR_DUMMY;
                     s_next.cnt = {2'b00, s_reg.plan.dummy_clks};
                  end else begin
                     s_next.st = MFR_DATA;
                  end
               end
            end
            MFR_DUMMY: begin
               s_next.cnt = s_reg.cnt - 6'd1;
               if (s_reg.cnt == 6'd1) begin
                  s_next.st = MFR_DATA;
               end
            end
            MFR_CFG: begin
               s_next.sh  = shift_in(s_reg.sh, s_reg.plan.addr_lane, lk.io);
               s_next.cnt = s_reg.cnt - 6'd1;
               if (s_reg.cnt == 6'd1) begin
                  if (s_reg.plan.kind == MFR_K_WRAPCFG) begin
                     s_next.wrap_dis = s_next.sh[4];
                     s_next.wrap_len = s_next.sh[6:5];
                  end else begin
                     s_next.dummy_sel = s_next.sh[5:4];
                     s_next.wrap_len  = s_next.sh[1:0];
                  end
                  s_next.st = MFR_IGNORE;
               end
            end
            MFR_IDLE, MFR_DATA, MFR_IGNORE: s_next.st = s_reg.st;
         endcase
      end else if (sclk_fall && s_reg.st == MFR_DATA) begin
         // data leaves on the falling edge, top bits first
         s_next.oe = (s_reg.plan.data_lane == 2'd1) ? 4'h3 : 4'hF;
         if (s_reg.nib == 3'd0) begin
            s_next.addr = next_addr(s_reg.addr, s_reg.plan.wrap, s_reg.wrap_len);
            if (s_reg.plan.data_lane == 2'd1) begin
               s_next.io     = {2'b00, rd_byte[7:6]};
               s_next.out_sh = {rd_byte[5:0], 2'b00};
               s_next.nib    = 3'd3;
            end else begin
               s_next.io     = rd_byte[7:4];
               s_next.out_sh = {rd_byte[3:0], 4'h0};
               s_next.nib    = 3'd1;
            end
         end else begin
            s_next.nib = s_reg.nib - 3'd1;
            if (s_reg.plan.data_lane == 2'd1) begin
               s_next.io     = {2'b00, s_reg.out_sh[7:6]};
               s_next.out_sh = {s_reg.out_sh[5:0], 2'b00};
            end else begin
               s_next.io     = s_reg.out_sh[7:4];
               s_next.out_sh = {s_reg.out_sh[3:0], 4'h0};
            end
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg           <= '0;
         s_reg.st        <= MFR_IDLE;
         s_reg.wrap_dis  <= `MFR_RST_WRAP_DIS;
         s_reg.wrap_len  <= `MFR_RST_WRAP_LEN;
         s_reg.dummy_sel <= `MFR_RST_DUMMY_SEL;
         s_reg.mode_byte <= `MFR_RST_MODE_BYTE;
         s_reg.sclk_prev <= 1'b0;
         s_reg.cs_prev   <= 1'b1;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && mem_we) begin
         mem[s_reg.mem_addr[MEM_AW-1:0]] <= wb.dat[7:0];
      end
   end

   assign wb_dat_o = s_reg.dat;
   assign wb_ack_o = s_reg.ack;
   assign io_o     = s_reg.io;
   assign io_oe_o  = s_reg.oe;

endmodule // mfr_engine

`default_nettype wire

// File: mfr_engine_properties.sv
// Purpose: port checks of the read engine
// Assumes: link and bus timing as handed over
// Notes:   bound to every mfr_engine
`default_nettype none
module mfr_engine_properties (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        sclk_i,
   input wire logic        cs_n_i,
   input wire logic [3:0]  io_o,
   input wire logic [3:0]  io_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ****
   // bus
   // ****
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_ack_lat; ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
   // ****
   // link
   // ****
   property p_idle; cs_n_i [*8] |-> io_oe_o == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("driven while deselected");
   property p_drop; $rose(cs_n_i) |-> ##[1:6] io_oe_o == 4'h0; endproperty
   a_drop: assert property (p_drop) else $error("io not released");
   property p_lanes; io_oe_o inside {4'h0, 4'h3, 4'hF}; endproperty
   a_lanes: assert property (p_lanes) else $error("bad lane set");
   property p_fall; $changed(io_o) || $changed(io_oe_o) |-> !sclk_i; endproperty
   a_fall: assert property (p_fall) else $error("io moved while sclk high");
   property p_sel; io_oe_o != 4'h0 |-> !$past(cs_n_i, 5); endproperty
   a_sel: assert property (p_sel) else $error("driven without select");
endmodule // mfr_engine_properties
bind mfr_engine mfr_engine_properties mfr_engine_properties_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .io_o(io_o), .io_oe_o(io_oe_o));
`default_nettype wire

// File: mfr_host.sv
// Purpose: host controller model driving the link
// Assumes: 4 ns bench clock, 64 ns serial clock
// Notes:   released lines are filled in by the bench
`default_nettype none
module mfr_host (
   input  wire logic       clk_i,
   input  wire logic [3:0] io_i,
   output logic            sclk_o = 1'b0,
   output logic            cs_n_o = 1'b1,
   output logic      [3:0] io_o = 4'h0,
   output logic      [3:0] oe_o = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // one serial clock: lines set while low, sampled just before rise
   task automatic bc(input logic [3:0] v, input logic [3:0] e, output logic [3:0] s);
      io_o <= v;
      oe_o <= e;
      repeat (7) @(posedge clk_i);
      @(negedge clk_i);
      s = io_i;
      @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b0;
   endtask
   task automatic tx(input int w, input int n, input logic [31:0] d);
      logic [3:0] s;
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      for (int i = n - w; i >= 0; i -= w) bc(4'(d >> i) & m, m, s);
   endtask
   task automatic rx(input int w, input int n, output logic [31:0] q);
      logic [3:0] s;
      q = 0;
      for (int i = 0; i < n; i += w) begin
         bc(4'h0, 4'h0, s);
         q = (q << w) | 32'(s & 4'((1 << w) - 1));
      end
   endtask
   task automatic cs(input logic v);
      repeat (8) @(posedge clk_i);
      cs_n_o <= v;
      oe_o <= 4'h0;
      repeat (8) @(posedge clk_i);
   endtask
endmodule // mfr_host
`default_nettype wire

// File: mfr_engine_tb.sv
// Purpose: self-checking bench of mfr_engine
// Assumes: memory byte i below 64 holds i xor 5A
// Notes:   MEM_AW 8
`default_nettype none
module mfr_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, tgl = 0, seen = 0, ce = 1, ack, sclk, cs_n;
   logic [7:0]  adr = 0;
   logic [31:0] dat = 0, q, rdat;
   logic [3:0]  hio, hoe, dio, doe, sel = 4'hF;
   wire logic [3:0] io = (doe & dio) | (hoe & hio) | (~(doe | hoe) & (tgl ? 4'hA : 4'h5));
   int n_fail = 0, n_tests = 0;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) tgl <= ~tgl;
   always @(posedge clk_i) if (doe !== 4'h0) seen <= 1'b1;
   mfr_engine #(.MEM_AW(8)) mfr_engine_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io), .io_o(dio), .io_oe_o(doe));
   mfr_host h (.clk_i(clk_i), .io_i(io), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio), .oe_o(hoe));
   task automatic finish_test;
      $display("tests %0d failed %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      cyc <= 1; we <= w; adr <= a; dat <= d;
      for (k = 0; k < 99 && ack !== 1'b1; k++) @(posedge clk_i);
      if (k == 99) begin
         n_fail++;
         finish_test;
      end
      q = rdat;
      cyc <= 0;
      @(posedge clk_i);
   endtask
   function automatic logic [31:0] ex(int a, int n, int wl);
      ex = 0;
      for (int j = 0; j < n; j++) ex = (ex << 8) | 32'(8'(wl ? (a & -wl) | ((a + j) & (wl - 1)) : a + j) ^ 8'h5A);
   endfunction
   task automatic t_regs;
      wb(0, 8'h00, 0); chk(q, 0);
      wb(0, 8'h04, 0); chk(q, 32'h4);
      wb(0, 8'hFC, 0); chk(q, 0);
      sel <= 4'hE; wb(1, 8'h08, 5); sel <= 4'hF;
      for (int i = 0; i < 64; i++) wb(1, 8'h0C, 32'(i) ^ 32'h5A);
      $display("regs done");
   endtask
   task automatic t_qout;
      logic [31:0] c [3] = '{32'h0, 32'h5, 32'h1};
      foreach (c[i]) begin
         wb(1, 8'h00, c[i]);
         seen <= 0;
         h.cs(0); h.tx(1, 8, 32'h6B); h.tx(1, 24, 32'h5); h.rx(1, 8, q); h.rx(4, 32, q); h.cs(1);
         if (i == 2) chk(q, ex(5, 4, 0));
         else chk({31'h0, seen}, 0);
      end
      $display("qout done");
   endtask
   task automatic t_dual;
      h.cs(0); h.tx(1, 8, 32'hBB); h.tx(2, 24, 32'h10); h.tx(2, 8, 32'h20); h.rx(2, 16, q); h.cs(1);
      chk(q, ex(16, 2, 0));
      wb(0, 8'h04, 0); chk(q & 32'hFF01, 32'h2001);
      h.cs(0); h.tx(2, 24, 32'h21); h.tx(2, 8, 32'h0); h.rx(2, 8, q); h.cs(1);
      chk(q, ex(33, 1, 0));
      wb(0, 8'h04, 0); chk(q & 32'h1, 0);
      $display("dual done");
   endtask
   task automatic t_wrap;
      h.cs(0); h.tx(1, 8, 32'h77); h.tx(1, 32, 32'h0); h.cs(1);
      h.cs(0); h.tx(1, 8, 32'hEB); h.tx(4, 24, 32'h6); h.tx(4, 8, 32'h20); h.rx(1, 4, q); h.rx(4, 32, q); h.cs(1);
      chk(q, ex(6, 4, 8));
      h.cs(0); h.tx(4, 24, 32'hF); h.tx(4, 8, 32'h20); h.rx(1, 4, q); h.rx(4, 16, q); h.cs(1);
      chk(q, ex(15, 2, 8));
      h.cs(0); h.tx(4, 32, -1); h.cs(1); h.cs(0); h.tx(1, 8, 32'hFF); h.cs(1);
      wb(0, 8'h04, 0); chk(q & 32'hFF02, 0);
      h.cs(0); h.tx(1, 8, 32'h77); h.tx(1, 32, 32'h70); h.cs(1);
      wb(0, 8'h04, 0); chk(q & 32'h1C, 32'h1C);
      $display("wrap done");
   endtask
   task automatic t_fln;
      wb(1, 8'h00, 32'h3);
      wb(0, 8'h04, 0); chk(q & 32'h18, 32'h18);
      h.cs(0); h.tx(4, 8, 32'hC0); h.tx(4, 8, 32'h31); h.cs(1);
      wb(0, 8'h04, 0); chk(q & 32'h7C, 32'h6C);
      h.cs(0); h.tx(4, 8, 32'h0C); h.tx(4, 24, 32'hE); h.rx(1, 10, q); h.rx(4, 24, q); h.cs(1);
      chk(q, ex(14, 3, 16));
      h.cs(0); h.tx(4, 8, 32'hEB); h.tx(4, 24, 32'hF); h.tx(4, 8, 32'h0); h.rx(1, 8, q); h.rx(4, 16, q); h.cs(1);
      chk(q, ex(15, 2, 0));
      $display("fln done");
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      repeat (8) @(posedge clk_i);
      t_regs;
      t_qout;
      t_dual;
      t_wrap;
      t_fln;
      finish_test;
   end
endmodule // mfr_engine_tb
`default_nettype wire
